// ==== adc_control_and_result_regs_test.sv ====
// Self-checking testbench of the converter control block beside a behavioural core model.
`timescale 1ns/1ps
module adc_control_and_result_regs_test;
  logic clk;
  logic rst_n = 1'b0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic tick = 1'b0;
  logic uflow = 1'b0;
  logic pin_n = 1'b1;
  logic slow = 1'b0;
  logic rd_pend = 1'b0;
  logic align_s = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] exp_flags = 16'h0000;
  logic [15:0] exp_en = 16'h0000;
  logic [15:0] trig_s = 16'h0000;
  logic [2:0] exp_in = 3'h0;
  logic [2:0] first_s = 3'h0;
  logic [2:0] last_s = 3'h0;
  logic [3:0] ticks = 4'h0;
  logic [3:0] exp_ticks = 4'h0;
  logic [23:0] nx;
  logic [23:0] exp_q[$];
  logic [11:0] raw [8];
  logic [15:0] rdata;
  logic [11:0] res;
  logic [2:0] in_o;
  logic smp_o, conv_o, done, irq;
  int n_fail = 0;
  int tests_run = 0;
  int n_done = 0;

  adcr_top u_dut (.REF_CLK(clk), .RESET_N(rst_n), .ADDR(addr), .WR_DATA(wdata), .WR_EN(wr_en), .RD_EN(rd_en),
    .RD_DATA(rdata), .TIMER_CLK_EN(tick), .TIMER_UNDERFLOW(uflow), .EXT_TRIGGER_PIN_N(pin_n),
    .CORE_SAMPLE(smp_o), .CORE_CONVERT(conv_o), .CORE_INPUT(in_o), .CORE_DONE(done), .CORE_RESULT(res), .IRQ(irq));
  adcr_core_model u_core (.clk(clk), .rst_n(rst_n), .convert(conv_o), .slow(slow), .done(done), .result(res));

  //////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // The timer clock is a one-cycle enable every third cycle, so sampling spans many system cycles.
  initial begin
    forever begin
      repeat (2) @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
    end
  end

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    if (a == adcr_pkg::OFS_FLAGS) exp_flags = exp_flags & ~d;
    if (a == adcr_pkg::OFS_ENABLES) exp_en = d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    exp_q.push_back({a, e});
    @(posedge clk);
    rd_en <= 1'b0;
  endtask

  task automatic chk_irq();
    @(negedge clk);
    check("irq", {15'h0000, irq}, {15'h0000, |(exp_flags & exp_en)});
  endtask

  task automatic chk_res(input logic [2:0] fs, input logic [2:0] ls);
    for (int m = fs; m <= ls; m++) rd(8'(adcr_pkg::OFS_RESULT0 + 4 * m), align_s ? {raw[m], 4'h0} : {4'h0, raw[m]});
  endtask

  // Runs one triggered sweep and expects exactly n completions for a one-time sweep and at least n for a repeating one, then no more once it has stopped.
  task automatic sweep(input logic [1:0] src, input logic rep, input logic [2:0] fs, input logic [2:0] ls, input int n);
    int base;
    logic [2:0] smp;
    base = n_done;
    smp = 3'($urandom_range(7));
    wr(adcr_pkg::OFS_CTRL, 16'h0001);
    first_s = fs;
    last_s = ls;
    exp_in = fs;
    exp_ticks = {1'b0, smp} + 4'h4;
    trig_s = {2'b00, ls, fs, align_s, rep, src, 1'b0, smp};
    wr(adcr_pkg::OFS_TRIG, trig_s);
    repeat (6) @(posedge clk);
    wr(adcr_pkg::OFS_CTRL, 16'h0003);
    @(posedge clk);
    uflow <= (src == 2'h1);
    pin_n <= (src != 2'h3);
    repeat (5) @(posedge clk);
    uflow <= 1'b0;
    pin_n <= 1'b1;
    for (int i = 0; i < 4000 && n_done < base + n; i++) @(posedge clk);
    if (n_done < base + n) begin
      n_fail++;
      $display("[FAIL] sweep expected %0d seen %0d", base + n, n_done);
      results();
    end
    if (rep) wr(adcr_pkg::OFS_CTRL, 16'h0001);
    repeat (150) @(posedge clk);
    if (rep) base = n_done - n;
    repeat (150) @(posedge clk);
    check("conversions", 16'(n_done), 16'(base + n));
  endtask

  //////////////////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (rd_pend) begin
      nx = exp_q.pop_front();
      check($sformatf("reg %h", nx[23:16]), rdata, nx[15:0]);
    end
    rd_pend <= rd_en;
    if (smp_o && tick) ticks <= ticks + 4'h1;
    if (conv_o) begin
      check("sample ticks", {12'h000, ticks}, {12'h000, exp_ticks});
      check("input order", {13'h0000, in_o}, {13'h0000, exp_in});
      exp_in <= (exp_in == last_s) ? first_s : exp_in + 3'h1;
      ticks <= 4'h0;
    end
    if (done) begin
      raw[in_o] <= res;
      if (exp_flags[{1'b0, in_o}]) exp_flags[{1'b1, in_o}] = 1'b1;
      exp_flags[{1'b0, in_o}] = 1'b1;
      n_done++;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h9e21));
    for (int k = 0; k < 8; k++) raw[k] = 12'h000;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    wr(adcr_pkg::OFS_RESULT0, 16'hffff);
    rd(adcr_pkg::OFS_TRIG, 16'h0007);
    rd(adcr_pkg::OFS_CTRL, 16'h0000);
    rd(adcr_pkg::OFS_CFG, 16'h0000);
    rd(adcr_pkg::OFS_FLAGS, 16'h0000);
    rd(adcr_pkg::OFS_ENABLES, 16'h0000);
    rd(8'h40, 16'h0000);
    chk_res(3'h0, 3'h7);
    $display("test reset values done");
    for (int v = 0; v < 3; v++) begin
      wr(adcr_pkg::OFS_CFG, 16'(v));
      sweep(2'h0, 1'b0, 3'h0, 3'h2, 0);
    end
    wr(adcr_pkg::OFS_CFG, 16'h0003);
    $display("test range gate done");
    sweep(2'h0, 1'b0, 3'h1, 3'h3, 3);
    rd(adcr_pkg::OFS_FLAGS, exp_flags);
    rd(adcr_pkg::OFS_CTRL, 16'h3003);
    for (int a = 1; a >= 0; a--) begin
      align_s = a[0];
      wr(adcr_pkg::OFS_TRIG, {trig_s[15:8], align_s, trig_s[6:0]});
      chk_res(3'h1, 3'h3);
    end
    $display("test one-time and alignment done");
    slow = 1'b1;
    sweep(2'h0, 1'b0, 3'h1, 3'h3, 3);
    rd(adcr_pkg::OFS_FLAGS, exp_flags);
    chk_irq();
    for (int i = 15; i >= 0; i--) begin
      if (i == 9 || i == 2) begin
        wr(adcr_pkg::OFS_ENABLES, 16'h0001 << i);
        chk_irq();
        wr(adcr_pkg::OFS_FLAGS, 16'h0001 << i);
        chk_irq();
      end
    end
    rd(adcr_pkg::OFS_FLAGS, exp_flags);
    rd(adcr_pkg::OFS_ENABLES, 16'h0004);
    $display("test flags and interrupt done");
    slow = 1'b0;
    for (int s = 1; s < 4; s++) sweep(2'(s), 1'b0, 3'h0, 3'h7, (s == 2) ? 0 : 8);
    $display("test trigger sources done");
    wr(adcr_pkg::OFS_FLAGS, 16'hffff);
    sweep(2'h0, 1'b1, 3'h5, 3'h6, 5);
    rd(adcr_pkg::OFS_FLAGS, exp_flags);
    chk_res(3'h5, 3'h6);
    $display("test continuous done");
    results();
  end
endmodule

// ==== adcr_core_model.sv ====
// Behavioural model of the analog converter core that answers convert requests.
`timescale 1ns/1ps
module adcr_core_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic convert,
  input wire logic slow,
  output logic done,
  output logic [11:0] result
);
  logic [3:0] wait_q;
  // Between strobes the data lines toggle between the last value and its inverse every cycle, so a stale capture is caught.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 4'h0;
      done <= 1'b0;
      result <= 12'h000;
    end else begin
      done <= 1'b0;
      result <= ~result;
      if (convert) begin
        wait_q <= slow ? 4'h6 : 4'h1;
      end else if (wait_q == 4'h1) begin
        wait_q <= 4'h0;
        done <= 1'b1;
        result <= 12'($urandom);
      end else if (wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
      end
    end
  end
endmodule

// ==== adcr_pkg.sv ====
// Package with register map, field layout, reset values and types of the converter control block.
package adcr_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned RES_W = 12;
  localparam int unsigned NUM_INPUTS = 8;
  localparam int unsigned CH_W = 3;

  // Register byte addresses, one aligned word each.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TRIG = 8'h04;
  localparam logic [7:0] OFS_CFG = 8'h08;
  localparam logic [7:0] OFS_FLAGS = 8'h0C;
  localparam logic [7:0] OFS_ENABLES = 8'h10;
  localparam logic [7:0] OFS_RESULT0 = 8'h20;
  localparam logic [7:0] OFS_RESULT_END = 8'h3C;

  // Control register fields.
  localparam int unsigned CTRL_MODULE_EN_BIT = 0;
  localparam int unsigned CTRL_START_BIT = 1;
  localparam int unsigned CTRL_BUSY_BIT = 10;
  localparam int unsigned CTRL_CUR_INPUT_LSB = 12;

  // Trigger and input select register fields.
  localparam int unsigned TRIG_SMP_LSB = 0;
  localparam int unsigned TRIG_SRC_LSB = 4;
  localparam int unsigned TRIG_REPEAT_BIT = 6;
  localparam int unsigned TRIG_ALIGN_BIT = 7;
  localparam int unsigned TRIG_FIRST_LSB = 8;
  localparam int unsigned TRIG_LAST_LSB = 11;

  // Flag and enable layout.
  localparam int unsigned FLAG_DONE_LSB = 0;
  localparam int unsigned FLAG_OVF_LSB = 8;

  // Reset values.
  localparam logic [2:0] RST_SAMPLE_TIME = 3'h7;
  localparam logic [1:0] RST_TRIG_SRC = 2'h0;
  localparam logic [1:0] RST_VOLTAGE_RANGE_SEL = 2'h0;
  localparam logic [15:0] RST_RESULT = 16'h0000;

  // Sampling length is the field value plus this many timer clock cycles.
  localparam logic [3:0] SAMPLE_BASE_CYCLES = 4'h4;

  // Voltage range code that lets conversions run.
  localparam logic [1:0] VOLTAGE_RANGE_SEL_RUN = 2'h3;

  typedef enum logic [1:0] {
    TRIG_SOFTWARE = 2'b00,
    TRIG_TIMER = 2'b01,
    TRIG_RESERVED = 2'b10,
    TRIG_PIN = 2'b11
  } adcr_trig_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONVERT = 2'b10
  } adcr_state_t;

  // Places a raw 12-bit value left or right in a 16-bit word.
  function automatic logic [15:0] adcr_align(input logic [11:0] raw, input logic left);
    adcr_align = left ? {raw, 4'h0} : {4'h0, raw};
  endfunction

endpackage

// ==== adcr_result_mem.sv ====
// Small result store, one raw conversion word per analog input, with registered read data.
`timescale 1ns/1ps
module adcr_result_mem #(
  parameter int unsigned DEPTH = 8,
  parameter int unsigned WIDTH = 12
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data_q
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  // Entries reset to zero so that unconverted inputs read as zero.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_q <= '0;
    end else if (rd_en) begin
      rd_data_q <= mem_q[rd_addr];
    end
  end

endmodule

// ==== adcr_top.sv ====
// Control, trigger sequencing, flags and result registers of a 12-bit converter channel.
//
// Overview of operation
// - With the alignment selector at 1 every result reads left-justified, at 0 right-justified.
// - A change of alignment re-presents all stored results at once without touching the stored values.
// - A result is 12 bits in 16, in bits 15 to 4 with low bits zero or in bits 11 to 0 with high bits zero.
// - The repeat selector picks continuous conversion at 1 and one-time conversion at 0.
// - Trigger source 3 is the external pin, 1 the timer underflow, 0 the software start bit, 2 reserved.
// - Sampling lasts the sampling field value plus four timer clock cycles, 4 to 11 cycles.
// - No conversion runs while the voltage range is 0; only 3 enables operation, 1 and 2 are reserved.
// - Flags hold overwrite errors per input in bits 15 to 8 and completions per input in bits 7 to 0.
// - Writing 1 to a flag bit clears it and writing 0 leaves it alone.
// - The enable register has one enable per flag at the same position, 1 enabling the interrupt.
// - Each input has a read-only 16-bit result register holding its latest result, reset to zero.
// - Loading a result sets its completion flag and, if that flag was already set, its overwrite flag.
// - Conversion carries on after an overwrite error.
// - The interrupt is raised only while some flag and its enable are both set.
`timescale 1ns/1ps
module adcr_top (
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire logic [7:0] ADDR,
  input wire logic [15:0] WR_DATA,
  input wire logic WR_EN,
  input wire logic RD_EN,
  output logic [15:0] RD_DATA,
  input wire logic TIMER_CLK_EN,
  input wire logic TIMER_UNDERFLOW,
  input wire logic EXT_TRIGGER_PIN_N,
  output logic CORE_SAMPLE,
  output logic CORE_CONVERT,
  output logic [2:0] CORE_INPUT,
  input wire logic CORE_DONE,
  input wire logic [11:0] CORE_RESULT,
  output logic IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and trigger pin synchroniser.

  logic rst_s1_q, rst_n_s;

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_s1_q <= 1'b0;
      rst_n_s <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_s <= rst_s1_q;
    end
  end

  // The pin idles high; a trigger is a falling edge seen by the second and third stages.
  logic pin_s1_q, pin_s2_q, pin_s3_q;

  always_ff @(posedge REF_CLK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      pin_s1_q <= 1'b1;
      pin_s2_q <= 1'b1;
      pin_s3_q <= 1'b1;
    end else begin
      pin_s1_q <= EXT_TRIGGER_PIN_N;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  wire pin_fall = pin_s3_q & ~pin_s2_q;

  ////////////////////////////////////////////////////////////////////////////
  // Register file.

  logic module_en_q, start_q, sw_go_q;
  logic [2:0] smp_sel_q, first_sel_q, last_sel_q;
  logic [1:0] src_sel_q, voltage_range_sel_q;
  logic repeat_q, align_q;
  logic [15:0] flags_q, flags_d, inte_q;
  adcr_pkg::adcr_state_t state_q, state_d;
  logic [2:0] cur_ch_q;

  wire wr_ctrl = WR_EN && (ADDR == adcr_pkg::OFS_CTRL);
  wire wr_trig = WR_EN && (ADDR == adcr_pkg::OFS_TRIG);
  wire wr_cfg = WR_EN && (ADDR == adcr_pkg::OFS_CFG);
  wire wr_flags = WR_EN && (ADDR == adcr_pkg::OFS_FLAGS);
  wire wr_inte = WR_EN && (ADDR == adcr_pkg::OFS_ENABLES);
  wire addr_result = (ADDR >= adcr_pkg::OFS_RESULT0) && (ADDR <= adcr_pkg::OFS_RESULT_END) && (ADDR[1:0] == 2'b00);
  wire [2:0] res_idx = ADDR[4:2];
  wire busy = (state_q != adcr_pkg::ST_IDLE);
  wire new_start = WR_DATA[adcr_pkg::CTRL_START_BIT];

  always_ff @(posedge REF_CLK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      module_en_q <= 1'b0;
      start_q <= 1'b0;
      sw_go_q <= 1'b0;
    end else begin
      sw_go_q <= wr_ctrl && new_start && !start_q;
      if (wr_ctrl) begin
        module_en_q <= WR_DATA[adcr_pkg::CTRL_MODULE_EN_BIT];
        start_q <= new_start;
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      smp_sel_q <= adcr_pkg::RST_SAMPLE_TIME;
      src_sel_q <= adcr_pkg::RST_TRIG_SRC;
      repeat_q <= 1'b0;
      align_q <= 1'b0;
      first_sel_q <= 3'h0;
      last_sel_q <= 3'h0;
    end else if (wr_trig) begin
      smp_sel_q <= WR_DATA[adcr_pkg::TRIG_SMP_LSB +: 3];
      src_sel_q <= WR_DATA[adcr_pkg::TRIG_SRC_LSB +: 2];
      repeat_q <= WR_DATA[adcr_pkg::TRIG_REPEAT_BIT];
      align_q <= WR_DATA[adcr_pkg::TRIG_ALIGN_BIT];
      first_sel_q <= WR_DATA[adcr_pkg::TRIG_FIRST_LSB +: 3];
      last_sel_q <= WR_DATA[adcr_pkg::TRIG_LAST_LSB +: 3];
    end
  end

  // A range change while busy is not blocked; software waits for idle first.
  always_ff @(posedge REF_CLK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      voltage_range_sel_q <= adcr_pkg::RST_VOLTAGE_RANGE_SEL;
      inte_q <= 16'h0000;
    end else begin
      if (wr_cfg) begin
        voltage_range_sel_q <= WR_DATA[1:0];
      end
      if (wr_inte) begin
        inte_q <= WR_DATA;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trigger selection and conversion sequencer.

  // Reserved range codes are treated like the disabled code.
  wire run_ok = module_en_q && (voltage_range_sel_q == adcr_pkg::VOLTAGE_RANGE_SEL_RUN);
  wire trig_event = (src_sel_q == adcr_pkg::TRIG_SOFTWARE) ? sw_go_q :
                    (src_sel_q == adcr_pkg::TRIG_TIMER) ? (start_q && TIMER_UNDERFLOW) :
                    (src_sel_q == adcr_pkg::TRIG_PIN) ? (start_q && pin_fall) : 1'b0;
  wire [3:0] smp_target = {1'b0, smp_sel_q} + adcr_pkg::SAMPLE_BASE_CYCLES;
  logic [3:0] smp_cnt_q;
  wire smp_last = TIMER_CLK_EN && (smp_cnt_q == smp_target - 4'h1);
  wire load_result = (state_q == adcr_pkg::ST_CONVERT) && CORE_DONE;
  wire at_last = (cur_ch_q == last_sel_q);
  wire go_on = start_q && run_ok;
  wire restart = at_last && repeat_q && go_on;

  // Stopping takes effect after the conversion in flight, never mid-sample.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      adcr_pkg::ST_IDLE: begin
        if (trig_event && run_ok) begin
          state_d = adcr_pkg::ST_SAMPLE;
        end
      end
      adcr_pkg::ST_SAMPLE: begin
        if (smp_last) begin
          state_d = adcr_pkg::ST_CONVERT;
        end
      end
      adcr_pkg::ST_CONVERT: begin
        if (CORE_DONE) begin
          state_d = ((!at_last && go_on) || restart) ? adcr_pkg::ST_SAMPLE : adcr_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = adcr_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      state_q <= adcr_pkg::ST_IDLE;
      cur_ch_q <= 3'h0;
      smp_cnt_q <= 4'h0;
      CORE_CONVERT <= 1'b0;
    end else begin
      state_q <= state_d;
      CORE_CONVERT <= (state_q == adcr_pkg::ST_SAMPLE) && smp_last;
      if (state_d != adcr_pkg::ST_SAMPLE) begin
        smp_cnt_q <= 4'h0;
      end else if (TIMER_CLK_EN && state_q == adcr_pkg::ST_SAMPLE) begin
        smp_cnt_q <= smp_cnt_q + 4'h1;
      end
      if (state_q == adcr_pkg::ST_IDLE && state_d == adcr_pkg::ST_SAMPLE) begin
        cur_ch_q <= first_sel_q;
      end else if (load_result && state_d == adcr_pkg::ST_SAMPLE) begin
        cur_ch_q <= restart ? first_sel_q : cur_ch_q + 3'h1;
      end
    end
  end

  assign CORE_SAMPLE = (state_q == adcr_pkg::ST_SAMPLE);
  assign CORE_INPUT = cur_ch_q;

  ////////////////////////////////////////////////////////////////////////////
  // Flags and interrupt.

  wire [7:0] load_mask = load_result ? (8'h01 << cur_ch_q) : 8'h00;
  wire [15:0] flag_set = {load_mask & flags_q[7:0], load_mask};
  wire [15:0] flag_clr = wr_flags ? WR_DATA : 16'h0000;

  // A load in the same cycle as a clear keeps the flag set.
  assign flags_d = (flags_q & ~flag_clr) | flag_set;

  always_ff @(posedge REF_CLK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      flags_q <= 16'h0000;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign IRQ = |(flags_q & inte_q);

  ////////////////////////////////////////////////////////////////////////////
  // Result store and read path.

  logic [11:0] mem_rd;
  logic rd_res_q;
  logic [15:0] rd_reg_q;

  adcr_result_mem #(
    .DEPTH(adcr_pkg::NUM_INPUTS),
    .WIDTH(adcr_pkg::RES_W)
  ) u_mem (
    .clk(REF_CLK),
    .rst_n(rst_n_s),
    .wr_en(load_result),
    .wr_addr(cur_ch_q),
    .wr_data(CORE_RESULT),
    .rd_en(RD_EN && addr_result),
    .rd_addr(res_idx),
    .rd_data_q(mem_rd)
  );

  wire [15:0] ctrl_view = {1'b0, cur_ch_q, 1'b0, busy, 8'h00, start_q, module_en_q};
  wire [15:0] trig_view = {2'b00, last_sel_q, first_sel_q, align_q, repeat_q, src_sel_q, 1'b0, smp_sel_q};
  wire [15:0] reg_view = (ADDR == adcr_pkg::OFS_CTRL) ? ctrl_view :
                         (ADDR == adcr_pkg::OFS_TRIG) ? trig_view :
                         (ADDR == adcr_pkg::OFS_CFG) ? {14'h0000, voltage_range_sel_q} :
                         (ADDR == adcr_pkg::OFS_FLAGS) ? flags_q :
                         (ADDR == adcr_pkg::OFS_ENABLES) ? inte_q : 16'h0000;

  always_ff @(posedge REF_CLK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      rd_res_q <= 1'b0;
      rd_reg_q <= 16'h0000;
    end else begin
      rd_res_q <= RD_EN && addr_result;
      rd_reg_q <= RD_EN ? reg_view : 16'h0000;
    end
  end

  // Raw values are stored and aligned on the way out, so an alignment change shows at once.
  assign RD_DATA = rd_res_q ? adcr_pkg::adcr_align(mem_rd, align_q) : rd_reg_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!rst_n_s);

  logic [3:0] ast_ticks_q;

  always_ff @(posedge REF_CLK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      ast_ticks_q <= 4'h0;
    end else if (!CORE_SAMPLE) begin
      ast_ticks_q <= 4'h0;
    end else if (TIMER_CLK_EN) begin
      ast_ticks_q <= ast_ticks_q + 4'h1;
    end
  end

  AST_LEFT_LOW_ZERO: assert property (rd_res_q && align_q |-> RD_DATA[3:0] == 4'h0)
    else $error("Left-justified result has nonzero low bits.");
  AST_RIGHT_HIGH_ZERO: assert property (rd_res_q && !align_q |-> RD_DATA[15:12] == 4'h0)
    else $error("Right-justified result has nonzero high bits.");
  AST_RANGE_BLOCKS: assert property (state_q == adcr_pkg::ST_IDLE && voltage_range_sel_q != adcr_pkg::VOLTAGE_RANGE_SEL_RUN
    |=> state_q == adcr_pkg::ST_IDLE)
    else $error("Conversion started with range disabled.");
  AST_DONE_FLAG: assert property (load_result |=> flags_q[$past(cur_ch_q)])
    else $error("Completion flag not set after result load.");
  AST_OVF_FLAG: assert property (load_result && flags_q[cur_ch_q] |=> flags_q[8 + $past(cur_ch_q)])
    else $error("Overwrite flag not set on reload.");
  AST_W1C_BIT0: assert property (wr_flags && WR_DATA[0] && !(load_result && cur_ch_q == 3'h0)
    |=> !flags_q[0])
    else $error("Flag bit 0 not cleared by writing one.");
  AST_IRQ_LEVEL: assert property (load_result && inte_q[cur_ch_q] && !wr_inte
    |=> IRQ)
    else $error("Enabled completion flag did not raise interrupt.");
  AST_SAMPLE_LEN: assert property ($fell(CORE_SAMPLE) |-> $past(ast_ticks_q) + 4'h1 == $past(smp_target))
    else $error("Sampling length differs from setting.");
  AST_ONE_TIME_STOP: assert property (load_result && at_last && !repeat_q
    |=> state_q == adcr_pkg::ST_IDLE)
    else $error("One-time sweep did not stop after last input.");
  AST_OVF_KEEPS_RUN: assert property (load_result && flags_q[cur_ch_q] && !at_last && go_on
    |=> state_q == adcr_pkg::ST_SAMPLE)
    else $error("Sweep stopped after overwrite error.");

  // Sequencing, read path, flag and interrupt checks; they pin down behaviour that the bench only sees from outside.
  AST_SWEEP_FIRST: assert property (state_q == adcr_pkg::ST_IDLE && state_d == adcr_pkg::ST_SAMPLE
    |=> cur_ch_q == $past(first_sel_q))
    else $error("Sweep did not start at the first input.");
  AST_RESTART_FIRST: assert property (load_result && restart
    |=> state_q == adcr_pkg::ST_SAMPLE && cur_ch_q == $past(first_sel_q))
    else $error("Continuous sweep did not restart at the first input.");
  AST_NEXT_INPUT: assert property (load_result && !at_last && go_on
    |=> cur_ch_q == $past(cur_ch_q) + 3'h1)
    else $error("Sweep skipped or repeated an input.");
  AST_STOP_IDLE: assert property (load_result && !start_q
    |=> state_q == adcr_pkg::ST_IDLE)
    else $error("Sweep went on after the start bit was cleared.");
  AST_RESERVED_SRC: assert property (src_sel_q == adcr_pkg::TRIG_RESERVED
    && state_q == adcr_pkg::ST_IDLE |=> state_q == adcr_pkg::ST_IDLE)
    else $error("Reserved trigger source started a sweep.");
  AST_CONVERT_ONE_CYCLE: assert property (CORE_CONVERT
    |=> !CORE_CONVERT)
    else $error("Convert request lasted more than one cycle.");
  AST_RD_IDLE_ZERO: assert property (!$past(RD_EN)
    |-> RD_DATA == 16'h0000)
    else $error("Read data not zero outside a read answer.");
  AST_OVF_W1C_BIT8: assert property (wr_flags && WR_DATA[8] && !(load_result && cur_ch_q == 3'h0)
    |=> !flags_q[8])
    else $error("Flag bit 8 not cleared by writing one.");
  AST_DONE_STICKY: assert property (flags_q[0] && !(wr_flags && WR_DATA[0])
    |=> flags_q[0])
    else $error("Completion flag dropped without a clear.");
  AST_IRQ_DROP: assert property ((flags_d & inte_q) == 16'h0000 && !wr_inte
    |=> !IRQ)
    else $error("Interrupt stayed high with no enabled flag.");

endmodule
